// *** logic/rdi_pkg.sv ***
// Shared types and constants for the remote digital input controller
package rdi_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_INPUTS = 24;
    localparam int IDX_W = 5;
    localparam int PRESET_W = 4;
    localparam int POWER_W = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int REPEAT_TIME_NS = 500_000_000;
    // Longest time, so rounding down is the safe direction
    localparam int REPEAT_CYCLES = REPEAT_TIME_NS / CLK_PERIOD_NS;
    localparam int REPEAT_CNT_W = 24;
    localparam logic [1:0] SYNC_PRIME_CYCLES = 2'h3;

    // ------------------------------------------------------------
    // Power stepping and reset values
    // ------------------------------------------------------------
    localparam logic [POWER_W-1:0] POWER_STEP_W = 16'h0064;
    localparam logic [POWER_W-1:0] POWER_RESET_W = 16'h0000;
    localparam logic [POWER_W-1:0] POWER_MAX_W = 16'hFFFF;
    localparam logic RF_RESET = 1'b0;
    localparam logic EXCITER_B_RESET = 1'b0;
    localparam logic AUTOCHG_RESET = 1'b0;
    localparam logic [PRESET_W-1:0] PRESET_RESET = 4'h0;

    // ------------------------------------------------------------
    // Channel functions and control modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FN_NONE     = 3'h0,
        FN_RF       = 3'h1,
        FN_RESET    = 3'h2,
        FN_POWER    = 3'h3,
        FN_EXCITER  = 3'h4,
        FN_AUTOCHG  = 3'h5,
        FN_WATCHDOG = 3'h6,
        FN_PRESET   = 3'h7
    } rdi_func_e;

    // Functions that act even in local mode, one bit per function code
    localparam logic [7:0] FUNC_EXEMPT = 8'h00;

    typedef enum logic [3:0] {
        MD_FALL_ON       = 4'h0,
        MD_RISE_ON       = 4'h1,
        MD_FALL_OFF      = 4'h2,
        MD_RISE_OFF      = 4'h3,
        MD_FALL_TOG      = 4'h4,
        MD_RISE_TOG      = 4'h5,
        MD_RISE_ON_FALL  = 4'h6,
        MD_FALL_ON_RISE  = 4'h7,
        MD_HIGH_INC      = 4'h8,
        MD_LOW_INC       = 4'h9,
        MD_HIGH_ON       = 4'hA,
        MD_LOW_ON        = 4'hB,
        MD_HIGH_DEC      = 4'hC,
        MD_LOW_DEC       = 4'hD
    } rdi_mode_e;

    typedef struct packed {
        rdi_func_e func;
        rdi_mode_e mode;
        logic [PRESET_W-1:0] preset;
    } rdi_cfg_s;

    // One-cycle command pulses toward the transmitter controller
    typedef struct packed {
        logic rfOn;
        logic rfOff;
        logic sysReset;
        logic watchdog;
        logic presetSel;
        logic [PRESET_W-1:0] presetIdx;
    } rdi_cmd_s;

endpackage

// *** logic/rdi_input_sync.sv ***
// Pin synchroniser and edge detector for the remote inputs
`timescale 1ns/100ps
`default_nettype none
module rdi_input_sync
    import rdi_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pins
    input wire logic [NUM_INPUTS-1:0] pinIn,
    // Conditioned inputs
    output logic [NUM_INPUTS-1:0] level,
    output logic [NUM_INPUTS-1:0] rise,
    output logic [NUM_INPUTS-1:0] fall
);

    logic [1:0] prime_reg, prime_next;
    logic primed;

    // ------------------------------------------------------------
    // Priming: no edges until the chain holds real pin values
    // ------------------------------------------------------------
    always_comb begin
        prime_next = prime_reg;
        if (prime_reg != SYNC_PRIME_CYCLES) begin
            prime_next = prime_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prime_reg <= 2'h0;
        end else begin
            prime_reg <= prime_next;
        end
    end

    assign primed = (prime_reg == SYNC_PRIME_CYCLES);

    // ------------------------------------------------------------
    // Per-pin two-flop chain and history
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_INPUTS; i++) begin : g_pin
            logic meta_reg, sync_reg, prev_reg;
            always_ff @(posedge clk_sys or posedge rst) begin
                // Reset to the pulled-up idle level
                if (rst) begin
                    meta_reg <= 1'b1;
                    sync_reg <= 1'b1;
                    prev_reg <= 1'b1;
                end else begin
                    meta_reg <= pinIn[i]; // see R22
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                end
            end
            assign level[i] = sync_reg;
            assign rise[i] = primed & sync_reg & ~prev_reg;
            assign fall[i] = primed & ~sync_reg & prev_reg;
        end
    endgenerate

endmodule
`default_nettype wire

// *** logic/rdi_repeat_step.sv ***
// Step generator: one step on assertion, then one per repeat period
`timescale 1ns/100ps
`default_nettype none
module rdi_repeat_step
    import rdi_pkg::*;
#(
    parameter int unsigned REPEAT = REPEAT_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Request level and step pulse
    input wire logic held,
    output logic step
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_HOLD = 2'h2
    } rdi_rep_e;

    localparam logic [REPEAT_CNT_W-1:0] LAST = REPEAT_CNT_W'(REPEAT - 1);

    rdi_rep_e state_reg, state_next;
    logic [REPEAT_CNT_W-1:0] cnt_reg, cnt_next;
    logic step_reg, step_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        step_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (held) begin
                    step_next = 1'b1; // see R7
                    cnt_next = '0;
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!held) begin
                    state_next = ST_IDLE;
                end else if (cnt_reg >= LAST) begin
                    step_next = 1'b1; // see R8
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            step_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            step_reg <= step_next;
        end
    end

    assign step = step_reg;

endmodule
`default_nettype wire

// *** logic/rdi_controller.sv ***
// Remote digital input controller: decodes 24 remote pins into commands
//
// Behaviour
// R1 - 24 inputs, each with function and mode
// R2 - Commands act only in remote mode
// R3 - Remote inputs never change remote/local selection
// R4 - Unassigned inputs have no effect
// R5 - RF channel issues RF on/off commands
// R6 - Reset channel issues system reset
// R7 - Each power activation steps 100 W
// R8 - Held power input repeats step each half second
// R9 - Exciter channel selects exciter A or B
// R10 - Auto changeover toggles enabled/disabled per activation
// R11 - Watchdog channel reboots operator interface processor
// R12 - Preset channel makes its preset active
// R13 - Turn-on modes activate, reset or select B
// R14 - Turn-off modes deactivate or select A
// R15 - Toggle modes alternate state per qualifying edge
// R16 - Rising on, falling off mode
// R17 - Falling on, rising off mode
// R18 - Level modes request power change while active
// R19 - Level preset modes select preset while active
// R20 - Two default RF inputs: on, off
// R21 - Selected input level and settings readable
// R22 - Two-flop synchroniser before edge detection
// R23 - Remote unit holds levels long enough
`timescale 1ns/100ps
`default_nettype none
module rdi_controller
    import rdi_pkg::*;
#(
    parameter int unsigned REPEAT = REPEAT_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Remote pins from the parallel remote unit
    input wire logic [NUM_INPUTS-1:0] remoteIn,
    // Per-input configuration from the operator interface
    input wire rdi_cfg_s [NUM_INPUTS-1:0] inCfg,
    // Remote/local selection, owned by the local operator interface
    input wire logic remoteMode,
    // Power setpoint load from the operator interface
    input wire logic powerLoad,
    input wire logic [POWER_W-1:0] powerLoadW,
    // Readback selection
    input wire logic [IDX_W-1:0] rdSel,
    // Command pulses
    output rdi_cmd_s cmd,
    output logic powerUpStep,
    output logic powerDownStep,
    // Function state
    output logic rfOnState,
    output logic exciterB,
    output logic autoChgEnabled,
    output logic [POWER_W-1:0] powerSetW,
    // Readback
    output logic rdLevel,
    output rdi_cfg_s rdCfg
);

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] lvl, rise, fall;

    rdi_input_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(remoteIn),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // ------------------------------------------------------------
    // Per-input mode decode
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] onEv, offEv, togEv, incAct, decAct, presAct;
    logic [NUM_INPUTS-1:0] isRf, isRst, isPow, isExc, isAcg, isWdg, isPre;

    genvar i;
    generate
        for (i = 0; i < NUM_INPUTS; i++) begin : g_dec // see R1
            rdi_mode_e md;
            rdi_func_e fn;
            logic allowed;
            assign md = inCfg[i].mode;
            assign fn = inCfg[i].func;
            // Local mode blocks all functions except exempted ones
            assign allowed = remoteMode | FUNC_EXEMPT[fn]; // see R2
            // Turn-on edges
            assign onEv[i] = ((md == MD_FALL_ON) & fall[i]) // see R13
                | ((md == MD_RISE_ON) & rise[i])
                | ((md == MD_RISE_ON_FALL) & rise[i]) // see R16
                | ((md == MD_FALL_ON_RISE) & fall[i]); // see R17
            assign offEv[i] = ((md == MD_FALL_OFF) & fall[i]) // see R14
                | ((md == MD_RISE_OFF) & rise[i])
                | ((md == MD_RISE_ON_FALL) & fall[i]) // see R16
                | ((md == MD_FALL_ON_RISE) & rise[i]); // see R17
            assign togEv[i] = ((md == MD_FALL_TOG) & fall[i]) // see R15
                | ((md == MD_RISE_TOG) & rise[i]);
            assign incAct[i] = ((md == MD_HIGH_INC) & lvl[i]) // see R18
                | ((md == MD_LOW_INC) & ~lvl[i]);
            assign decAct[i] = ((md == MD_HIGH_DEC) & lvl[i])
                | ((md == MD_LOW_DEC) & ~lvl[i]);
            assign presAct[i] = ((md == MD_HIGH_ON) & lvl[i]) // see R19
                | ((md == MD_LOW_ON) & ~lvl[i]);
            // FN_NONE matches no group
            assign isRf[i] = allowed & (fn == FN_RF); // see R4
            assign isRst[i] = allowed & (fn == FN_RESET);
            assign isPow[i] = allowed & (fn == FN_POWER);
            assign isExc[i] = allowed & (fn == FN_EXCITER);
            assign isAcg[i] = allowed & (fn == FN_AUTOCHG);
            assign isWdg[i] = allowed & (fn == FN_WATCHDOG);
            assign isPre[i] = allowed & (fn == FN_PRESET);
        end
    endgenerate

    // ------------------------------------------------------------
    // Power stepping
    // ------------------------------------------------------------
    logic incHeld, decHeld, incStep, decStep;

    // Turn-on and turn-off edge modes on a power channel step once; toggle edges do not step
    assign incHeld = |(isPow & (incAct | onEv)); // see R18
    assign decHeld = |(isPow & (decAct | offEv));

    rdi_repeat_step #(.REPEAT(REPEAT)) u_inc (
        .clk_sys(clk_sys),
        .rst(rst),
        .held(incHeld),
        .step(incStep)
    );

    rdi_repeat_step #(.REPEAT(REPEAT)) u_dec (
        .clk_sys(clk_sys),
        .rst(rst),
        .held(decHeld),
        .step(decStep)
    );

    // ------------------------------------------------------------
    // Preset level history, so a held level selects once
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] presPrev_reg, presPrev_next;
    logic [NUM_INPUTS-1:0] presFire;

    assign presPrev_next = presAct & isPre;
    assign presFire = (isPre & onEv) | (presPrev_next & ~presPrev_reg); // see R12

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presPrev_reg <= '0;
        end else begin
            presPrev_reg <= presPrev_next;
        end
    end

    // ------------------------------------------------------------
    // Function state and command outputs
    // ------------------------------------------------------------
    rdi_cmd_s cmd_reg, cmd_next;
    logic rf_reg, rf_next;
    logic excB_reg, excB_next;
    logic acg_reg, acg_next;
    logic [POWER_W-1:0] pow_reg, pow_next;
    logic up_reg, up_next;
    logic down_reg, down_next;
    logic rfOnAny, rfOffAny, rfTogAny;

    assign rfOnAny = |(isRf & onEv);
    assign rfOffAny = |(isRf & offEv); // see R20
    assign rfTogAny = |(isRf & togEv);

    always_comb begin
        cmd_next = '0;
        rf_next = rf_reg;
        excB_next = excB_reg;
        acg_next = acg_reg;
        pow_next = pow_reg;
        up_next = 1'b0;
        down_next = 1'b0;

        // RF: on wins over off when both arrive together
        if (rfOnAny) begin
            cmd_next.rfOn = 1'b1; // see R5
            rf_next = 1'b1;
        end else if (rfOffAny) begin
            cmd_next.rfOff = 1'b1;
            rf_next = 1'b0;
        end else if (rfTogAny) begin
            cmd_next.rfOn = ~rf_reg; // see R15
            cmd_next.rfOff = rf_reg;
            rf_next = ~rf_reg;
        end

        // Reset acts on turn-on and toggle edges alike
        cmd_next.sysReset = |(isRst & (onEv | togEv)); // see R6
        cmd_next.watchdog = |(isWdg & (onEv | togEv)); // see R11

        // Exciter: on selects B, off selects A
        if (|(isExc & onEv)) begin
            excB_next = 1'b1; // see R9
        end else if (|(isExc & offEv)) begin
            excB_next = 1'b0;
        end else if (|(isExc & togEv)) begin
            excB_next = ~excB_reg;
        end

        if (|(isAcg & onEv)) begin
            acg_next = 1'b1;
        end else if (|(isAcg & offEv)) begin
            acg_next = 1'b0;
        end else if (|(isAcg & togEv)) begin
            acg_next = ~acg_reg; // see R10
        end

        // Lowest-numbered preset input wins a tie
        for (int k = NUM_INPUTS - 1; k >= 0; k--) begin
            if (presFire[k]) begin
                cmd_next.presetSel = 1'b1; // see R12
                cmd_next.presetIdx = inCfg[k].preset;
            end
        end

        // An operator load overrides a same-cycle step
        if (powerLoad) begin
            pow_next = powerLoadW;
        end else if (incStep && !decStep) begin
            up_next = 1'b1;
            if (pow_reg > POWER_MAX_W - POWER_STEP_W) begin
                pow_next = POWER_MAX_W;
            end else begin
                pow_next = pow_reg + POWER_STEP_W; // see R7
            end
        end else if (decStep && !incStep) begin
            down_next = 1'b1;
            if (pow_reg < POWER_STEP_W) begin
                pow_next = POWER_RESET_W;
            end else begin
                pow_next = pow_reg - POWER_STEP_W;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_reg <= '0;
            rf_reg <= RF_RESET;
            excB_reg <= EXCITER_B_RESET;
            acg_reg <= AUTOCHG_RESET;
            pow_reg <= POWER_RESET_W;
            up_reg <= 1'b0;
            down_reg <= 1'b0;
        end else begin
            cmd_reg <= cmd_next;
            rf_reg <= rf_next;
            excB_reg <= excB_next;
            acg_reg <= acg_next;
            pow_reg <= pow_next;
            up_reg <= up_next;
            down_reg <= down_next;
        end
    end

    // ------------------------------------------------------------
    // Readback of one selected input
    // ------------------------------------------------------------
    logic rdLevel_reg, rdLevel_next;
    rdi_cfg_s rdCfg_reg, rdCfg_next;

    always_comb begin
        rdLevel_next = 1'b0;
        rdCfg_next = '0;
        // Out-of-range selections read as zero
        if (rdSel < IDX_W'(NUM_INPUTS)) begin
            rdLevel_next = lvl[rdSel]; // see R21
            rdCfg_next = inCfg[rdSel];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdLevel_reg <= 1'b0;
            rdCfg_reg <= '0;
        end else begin
            rdLevel_reg <= rdLevel_next;
            rdCfg_reg <= rdCfg_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs; remoteMode is input only and never driven here
    // ------------------------------------------------------------
    assign cmd = cmd_reg; // see R3
    assign powerUpStep = up_reg;
    assign powerDownStep = down_reg;
    assign rfOnState = rf_reg;
    assign exciterB = excB_reg;
    assign autoChgEnabled = acg_reg;
    assign powerSetW = pow_reg;
    assign rdLevel = rdLevel_reg;
    assign rdCfg = rdCfg_reg;

endmodule
`default_nettype wire

// *** testbench/rdi_controller_asserts.sv ***
// Port checker for the remote digital input controller
`timescale 1ns/100ps
`default_nettype none
module rdi_controller_asserts
    import rdi_pkg::*;
#(
    parameter int unsigned REPEAT = REPEAT_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Inputs
    input wire logic [NUM_INPUTS-1:0] remoteIn,
    input wire rdi_cfg_s [NUM_INPUTS-1:0] inCfg,
    input wire logic remoteMode,
    input wire logic powerLoad,
    input wire logic [POWER_W-1:0] powerLoadW,
    input wire logic [IDX_W-1:0] rdSel,
    // Outputs
    input wire rdi_cmd_s cmd,
    input wire logic powerUpStep,
    input wire logic powerDownStep,
    input wire logic rfOnState,
    input wire logic exciterB,
    input wire logic autoChgEnabled,
    input wire logic [POWER_W-1:0] powerSetW,
    input wire logic rdLevel,
    input wire rdi_cfg_s rdCfg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Four local cycles flush the pipelines
    property p_local_quiet;
        (!remoteMode) [*4] |-> cmd == '0 && !powerUpStep && !powerDownStep;
    endproperty
    a_local_quiet: assert property (p_local_quiet) else $error("command in local");

    property p_rf_follow;
        (cmd.rfOn || cmd.rfOff) |-> rfOnState == cmd.rfOn;
    endproperty
    a_rf_follow: assert property (p_rf_follow) else $error("rf state wrong");

    property p_rf_cause;
        $changed(rfOnState) |-> cmd.rfOn || cmd.rfOff;
    endproperty
    a_rf_cause: assert property (p_rf_cause) else $error("rf state moved alone");

    property p_up_step;
        powerUpStep && !powerLoad && !$past(powerLoad) && $past(powerSetW) < 16'hFF9C
            |-> powerSetW == $past(powerSetW) + 16'h0064;
    endproperty
    a_up_step: assert property (p_up_step) else $error("bad up step");

    property p_dn_step;
        powerDownStep && !powerLoad && !$past(powerLoad) && $past(powerSetW) > 16'h0063
            |-> powerSetW == $past(powerSetW) - 16'h0064;
    endproperty
    a_dn_step: assert property (p_dn_step) else $error("bad down step");

    property p_step_excl;
        !(powerUpStep && powerDownStep);
    endproperty
    a_step_excl: assert property (p_step_excl) else $error("both steps");

    property p_rd_cfg;
        !$past(rst) && $past(rdSel) < 5'h18 |-> rdCfg == $past(inCfg[rdSel]);
    endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("readback cfg wrong");

    property p_rd_zero;
        !$past(rst) && $past(rdSel) >= 5'h18 |-> rdCfg == '0 && !rdLevel;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("readback not zero");

    // Pin to command takes three cycles
    property p_sync_delay;
        cmd.rfOn |-> $past(remoteIn, 3) != $past(remoteIn, 4);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("rf on latency");
endmodule

bind rdi_controller rdi_controller_asserts #(.REPEAT(REPEAT)) i_chk (
    .clk_sys(clk_sys), .rst(rst), .remoteIn(remoteIn), .inCfg(inCfg),
    .remoteMode(remoteMode), .powerLoad(powerLoad), .powerLoadW(powerLoadW),
    .rdSel(rdSel), .cmd(cmd), .powerUpStep(powerUpStep), .powerDownStep(powerDownStep),
    .rfOnState(rfOnState), .exciterB(exciterB), .autoChgEnabled(autoChgEnabled),
    .powerSetW(powerSetW), .rdLevel(rdLevel), .rdCfg(rdCfg)
);
`default_nettype wire

// *** testbench/rdi_remote_unit.sv ***
// Behavioural parallel remote control unit driving the remote pins
`timescale 1ns/100ps
`default_nettype none
module rdi_remote_unit
    import rdi_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Requests from the bench
    input wire logic setStb,
    input wire logic [IDX_W-1:0] setIdx,
    input wire logic setVal,
    // Pins
    output logic [NUM_INPUTS-1:0] pins
);
    // Idle pulled up; a level holds until the next request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pins <= '1;
        end else if (setStb) begin
            pins[setIdx] <= setVal;
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the remote digital input controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rdi_pkg::*;
    localparam int unsigned REP = 8;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic setStb = 1'h0;
    logic [IDX_W-1:0] setIdx = '0;
    logic setVal = 1'h1;
    logic [NUM_INPUTS-1:0] remoteIn;
    rdi_cfg_s [NUM_INPUTS-1:0] inCfg = '0;
    logic remoteMode = 1'h1;
    logic powerLoad = 1'h0;
    logic [POWER_W-1:0] powerLoadW = '0;
    logic [IDX_W-1:0] rdSel = '0;
    rdi_cmd_s cmd;
    logic powerUpStep, powerDownStep, rfOnState, exciterB, autoChgEnabled, rdLevel;
    logic [POWER_W-1:0] powerSetW;
    rdi_cfg_s rdCfg;
    logic [6:0] evts;
    int failCount = 0;
    int checkCount = 0;
    int cycles = 0;

    assign evts = {cmd.rfOn, cmd.rfOff, cmd.sysReset, cmd.watchdog, cmd.presetSel,
        powerUpStep, powerDownStep};

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    rdi_remote_unit i_remote (.clk_sys(clk_sys), .rst(rst), .setStb(setStb),
        .setIdx(setIdx), .setVal(setVal), .pins(remoteIn));

    rdi_controller #(.REPEAT(REP)) i_dut (.clk_sys(clk_sys), .rst(rst), .remoteIn(remoteIn),
        .inCfg(inCfg), .remoteMode(remoteMode), .powerLoad(powerLoad),
        .powerLoadW(powerLoadW), .rdSel(rdSel), .cmd(cmd), .powerUpStep(powerUpStep),
        .powerDownStep(powerDownStep), .rfOnState(rfOnState), .exciterB(exciterB),
        .autoChgEnabled(autoChgEnabled), .powerSetW(powerSetW), .rdLevel(rdLevel),
        .rdCfg(rdCfg));

    task automatic closeOut();
        $display("checks %0d mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            closeOut();
        end
    end

    task automatic check(input logic [31:0] exp, input logic [31:0] act);
        checkCount++;
        if (act !== exp) begin
            failCount++;
            $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic pin(input int idx, input logic val);
        @(posedge clk_sys);
        setStb <= 1'h1;
        setIdx <= idx[IDX_W-1:0];
        setVal <= val;
        @(posedge clk_sys);
        setStb <= 1'h0;
    endtask

    // Pin change plus settling time
    task automatic pc(input int idx, input logic val);
        pin(idx, val);
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_ev(input int b, output int n);
        n = 0;
        while (evts[b] !== 1'h1 && n < 12) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            check(0, evts);
        end
    endtask

    task automatic t_local();
        remoteMode <= 1'h0;
        pin(0, 1'h0);
        quiet(8);
        check(0, rfOnState);
        pin(0, 1'h1);
        remoteMode <= 1'h1;
        pin(5, 1'h0);
        quiet(8);
        pin(5, 1'h1);
        quiet(8);
    endtask

    task automatic t_rf();
        int n;
        pin(0, 1'h0);
        wait_ev(6, n);
        check(3, n);
        check(1, rfOnState);
        pin(0, 1'h1);
        pin(1, 1'h0);
        wait_ev(5, n);
        check(1, evts[5]);
        check(0, rfOnState);
        pin(1, 1'h1);
    endtask

    task automatic t_power();
        int n;
        pin(2, 1'h0);
        wait_ev(1, n);
        check(16'h0064, powerSetW);
        @(posedge clk_sys);
        #1;
        wait_ev(1, n);
        check(REP, n + 1);
        check(16'h00C8, powerSetW);
        pin(2, 1'h1);
        repeat (12) @(posedge clk_sys);
        check(16'h00C8, powerSetW);
        pin(3, 1'h0);
        wait_ev(0, n);
        check(16'h0064, powerSetW);
        pin(3, 1'h1);
        repeat (12) @(posedge clk_sys);
        check(16'h0064, powerSetW);
        powerLoad <= 1'h1;
        powerLoadW <= 16'hFFC8;
        @(posedge clk_sys);
        powerLoad <= 1'h0;
        pin(2, 1'h0);
        wait_ev(1, n);
        check(16'hFFFF, powerSetW);
        pin(2, 1'h1);
        repeat (12) @(posedge clk_sys);
    endtask

    task automatic t_states();
        pc(4, 1'h0);
        check(0, exciterB);
        pc(4, 1'h1);
        check(1, exciterB);
        pc(4, 1'h0);
        check(0, exciterB);
        inCfg[4].mode <= MD_FALL_ON_RISE;
        pc(4, 1'h1);
        check(0, exciterB);
        pc(4, 1'h0);
        check(1, exciterB);
        pc(6, 1'h0);
        check(1, autoChgEnabled);
        pc(6, 1'h1);
        check(1, autoChgEnabled);
        pc(6, 1'h0);
        check(0, autoChgEnabled);
        pc(23, 1'h0);
        check(0, rfOnState);
        pc(23, 1'h1);
        check(1, rfOnState);
        pc(23, 1'h0);
        pc(23, 1'h1);
        check(0, rfOnState);
    endtask

    task automatic t_cmds();
        int n;
        pin(7, 1'h0);
        pin(7, 1'h1);
        wait_ev(3, n);
        check(1, evts[3]);
        pin(8, 1'h0);
        wait_ev(4, n);
        check(1, evts[4]);
        pin(8, 1'h1);
        pin(9, 1'h0);
        wait_ev(2, n);
        check(5, cmd.presetIdx);
        quiet(8);
        pin(9, 1'h1);
    endtask

    task automatic t_readback();
        @(posedge clk_sys);
        rdSel <= 5'h09;
        repeat (2) @(posedge clk_sys);
        #1;
        check({1'h1, inCfg[9]}, {rdLevel, rdCfg});
        @(posedge clk_sys);
        rdSel <= 5'h18;
        repeat (2) @(posedge clk_sys);
        #1;
        check(0, {rdLevel, rdCfg});
    endtask

    initial begin
        inCfg[0] = '{FN_RF, MD_FALL_ON, 4'h0};
        inCfg[1] = '{FN_RF, MD_FALL_OFF, 4'h0};
        inCfg[2] = '{FN_POWER, MD_LOW_INC, 4'h0};
        inCfg[3] = '{FN_POWER, MD_LOW_DEC, 4'h0};
        inCfg[4] = '{FN_EXCITER, MD_RISE_ON_FALL, 4'h0};
        inCfg[6] = '{FN_AUTOCHG, MD_FALL_TOG, 4'h0};
        inCfg[7] = '{FN_WATCHDOG, MD_RISE_ON, 4'h0};
        inCfg[8] = '{FN_RESET, MD_FALL_ON, 4'h0};
        inCfg[9] = '{FN_PRESET, MD_LOW_ON, 4'h5};
        inCfg[23] = '{FN_RF, MD_RISE_TOG, 4'h0};
        repeat (6) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (5) @(posedge clk_sys);
        #1;
        check(0, {powerSetW, rfOnState, exciterB, autoChgEnabled});
        t_local();
        t_rf();
        t_power();
        t_states();
        t_cmds();
        t_readback();
        closeOut();
    end
endmodule
`default_nettype wire
